// File: rtl/ufc_pkg.sv
// Purpose: shared constants and carriers for the uart flow control block
// Assumes: apb register map with one 32-bit word per register
// Notes:   thresholds are nibbles scaled by four into receive levels
package ufc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_FEAT   = 8'h00;
  localparam logic [7:0] OFF_THRESH = 8'h04;
  localparam logic [7:0] OFF_MODEM  = 8'h08;
  localparam logic [7:0] OFF_INTEN  = 8'h0c;
  localparam logic [7:0] OFF_INTID  = 8'h10;
  localparam logic [7:0] OFF_LCR    = 8'h14;
  localparam logic [7:0] OFF_RES1   = 8'h18;
  localparam logic [7:0] OFF_RES2   = 8'h1c;
  localparam logic [7:0] OFF_HALT1  = 8'h20;
  localparam logic [7:0] OFF_HALT2  = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  // field positions
  localparam int FEAT_AUTO_CTS = 7;
  localparam int FEAT_AUTO_RTS = 6;
  localparam int FEAT_SPECIAL  = 5;
  localparam int MODEM_ANY_RES = 5;
  localparam int MODEM_RTS     = 1;
  localparam int INTEN_HALT    = 5;
  // reset values
  localparam logic [7:0] FEAT_RST   = 8'h00;
  localparam logic [7:0] THRESH_RST = 8'h00;
  localparam logic [7:0] MODEM_RST  = 8'h00;
  localparam logic [7:0] INTEN_RST  = 8'h00;
  localparam logic [7:0] LCR_RST    = 8'h03;
  // identification codes
  localparam logic [5:0] INTID_NONE = 6'h01;
  localparam logic [5:0] INTID_HALT = 6'h10;
  // flow character slots
  localparam int CH_RES1  = 0;
  localparam int CH_RES2  = 1;
  localparam int CH_HALT1 = 2;
  localparam int CH_HALT2 = 3;
  localparam int LVL_SHIFT = 2;

  typedef struct packed {
    logic       err;
    logic [7:0] data;
  } ufc_rx_t;

  typedef struct packed {
    logic [1:0] cnt;
    logic [7:0] c0;
    logic [7:0] c1;
  } ufc_seq_t;

  function automatic logic [7:0] ufc_wl_mask(input logic [1:0] wl);
    ufc_wl_mask = 8'hff >> (2'h3 - wl);
  endfunction
endpackage

// File: rtl/ufc_sync2.sv
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: din is asynchronous to clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module ufc_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // level
  input  wire logic din,
  output logic      dout
);
  logic meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// File: rtl/ufc_char_match.sv
// Purpose: compare a received character with one flow character
// Assumes: word length code 0..3 means 5..8 bits
// Notes:   upper bits beyond the word length are ignored
`timescale 1ns/10ps
module ufc_char_match
  import ufc_pkg::*;
(
  // operands
  input  wire logic [7:0] rx_char,
  input  wire logic [7:0] flow_char,
  input  wire logic [1:0] wl,
  // result
  output logic            hit
);
  assign hit = ((rx_char ^ flow_char) & ufc_wl_mask(wl)) == 8'h00;
endmodule

// File: rtl/ufc_flow_ctrl.sv
// Purpose: automatic hardware and software flow control for one uart channel
// Assumes: transmitter raises tx_busy the cycle after tx_start; rx_valid after stop bit
// Notes:   hardware and software flow control are never enabled together
// Contract
// [R01] two separate feature bits enable auto-cts and auto-rts independently
// [R02] with auto-cts, cts is checked low before each new character starts
// [R03] cts high before last stop midpoint blocks next character, current completes
// [R04] cts returning low lets the transmitter resume its queued characters
// [R05] auto-rts stays asserted below halt level, deasserts when level reached
// [R06] rts reasserts once receive level falls to the resume level
// [R07] remote may send one more character after rts deasserts, then stop
// [R08] feature bits 3:2 choose transmitted flow characters: none, one, two, pairs
// [R09] feature bits 1:0 choose receive comparison, either or sequential pairs
// [R10] with xon-any after a halt, any received character resumes transmission
// [R11] special character matching halt_char_two sets flag, stored, no halt
// [R12] received halt characters stop transmit after current, set flag, interrupt
// [R13] received resume characters restart transmit and clear the flag
// [R14] flow characters with parity, framing or break errors are plain data
// [R15] halt characters sent once receive level passes the halt level
// [R16] after a halt, resume characters sent when level reaches resume level
// [R17] selection change after halt sends old resume, then new halt if needed
// [R18] flow characters framed like data, only word-length low bits sent
// [R19] unmatched first character of a pair is stored as data
// [R20] software must not enable software and hardware flow control together
// [R21] resume_char_one may count as any-character resume, then two is stored
// [R22] without auto-cts, fifo data is sent whatever the cts level
// [R23] xoff interrupt reports code 010000, cleared by resume or ident read
// [R24] reset clears feature and threshold registers, keeps flow characters
// [R25] comparison happens only after the whole received frame
// [R26] flow characters go between fifo characters, never mid-character
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
module ufc_flow_ctrl
  import ufc_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // apb slave
  input  wire logic [ufc_pkg::ADDR_W-1:0] paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // modem pins
  input  wire logic                  cts_n,
  output logic                       rts_n,
  // transmit fifo and shifter
  input  wire logic                  tx_fifo_valid,
  input  wire logic [7:0]            tx_fifo_data,
  output logic                       tx_pop,
  input  wire logic                  tx_busy,
  output logic                       tx_start,
  output logic      [7:0]            tx_char,
  // receiver and receive_queue
  input  wire logic                  rx_valid,
  input  wire ufc_pkg::ufc_rx_t      rx_in,
  input  wire logic [6:0]            rx_level,
  output logic                       rx_store,
  output ufc_pkg::ufc_rx_t           rx_store_char,
  // interrupt
  output logic                       int_out
);
  import ufc_pkg::*;

  logic [1:0]  rst_q;
  logic        rst_n;
  logic [7:0]  enhanced_feature_reg;
  logic [7:0]  flow_threshold_reg;
  logic [7:0]  modem_ctrl_reg;
  logic [7:0]  int_enable_reg;
  logic [7:0]  line_ctrl;
  logic [7:0]  fchar [0:3];
  logic        wr;
  logic        rd;
  logic        ident_read;
  logic [31:0] next_prdata;
  logic        hit_addr;
  logic        cts_sync;
  logic        cts_ok;
  logic [6:0]  halt_lvl;
  logic [6:0]  resume_lvl;
  logic [7:0]  mask;
  logic [1:0]  tx_sel;
  logic [1:0]  rx_mode;
  logic        can_go;
  ufc_seq_t    q;
  logic        halt_sent;
  logic [1:0]  sent_sel;
  logic [3:0]  m;
  logic        either;
  logic        pair;
  logic        sng_off;
  logic        sng_on;
  logic        pair_off;
  logic        pair_on;
  logic        any_res;
  logic        ok;
  logic        new_pend;
  logic        do_off;
  logic        do_on;
  logic        eat;
  logic        flush;
  logic        pair_pend;
  logic        pair_kind;
  ufc_rx_t     pair_char;
  logic        stash_v;
  ufc_rx_t     stash_c;
  logic        xoff_halt;
  logic        xoff_flag;
  logic        flag_set;
  logic        flag_clr;

  // reset release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // apb: zero wait states, answer registered in the setup cycle
  assign wr         = psel & penable & pready & pwrite;
  assign rd         = psel & penable & pready & ~pwrite;
  assign ident_read = rd & (paddr == OFF_INTID);

  always_comb begin
    next_prdata = 32'h0;
    hit_addr    = 1'b1;
    case (paddr)
      OFF_FEAT:   next_prdata[7:0] = enhanced_feature_reg;
      OFF_THRESH: next_prdata[7:0] = flow_threshold_reg;
      OFF_MODEM:  next_prdata[7:0] = modem_ctrl_reg;
      OFF_INTEN:  next_prdata[7:0] = int_enable_reg;
      OFF_INTID:  next_prdata[5:0] = xoff_flag ? INTID_HALT : INTID_NONE; // [R23]
      OFF_LCR:    next_prdata[7:0] = line_ctrl;
      OFF_RES1:   next_prdata[7:0] = fchar[CH_RES1];
      OFF_RES2:   next_prdata[7:0] = fchar[CH_RES2];
      OFF_HALT1:  next_prdata[7:0] = fchar[CH_HALT1];
      OFF_HALT2:  next_prdata[7:0] = fchar[CH_HALT2];
      OFF_STATUS: next_prdata[5:0] = {pair_pend, halt_sent, xoff_halt, xoff_flag,
                                      ~cts_sync, ~rts_n};
      default:    hit_addr = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & ~hit_addr;
      if (psel & ~penable) begin
        prdata <= pwrite ? 32'h0 : next_prdata;
      end
    end
  end

  // control registers cleared by reset, except line control, which resets to 8'h03
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enhanced_feature_reg <= FEAT_RST;   // [R24]
      flow_threshold_reg   <= THRESH_RST; // [R24]
      modem_ctrl_reg       <= MODEM_RST;
      int_enable_reg       <= INTEN_RST;
      line_ctrl            <= LCR_RST;
    end else if (wr) begin
      case (paddr)
        OFF_FEAT:   enhanced_feature_reg <= pwdata[7:0];
        OFF_THRESH: flow_threshold_reg   <= pwdata[7:0];
        OFF_MODEM:  modem_ctrl_reg       <= pwdata[7:0];
        OFF_INTEN:  int_enable_reg       <= pwdata[7:0];
        OFF_LCR:    line_ctrl            <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // flow characters survive reset, so no reset branch
  always_ff @(posedge clk) begin
    if (wr) begin
      case (paddr)
        OFF_RES1:  fchar[CH_RES1]  <= pwdata[7:0]; // [R24]
        OFF_RES2:  fchar[CH_RES2]  <= pwdata[7:0];
        OFF_HALT1: fchar[CH_HALT1] <= pwdata[7:0];
        OFF_HALT2: fchar[CH_HALT2] <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // decode
  assign tx_sel     = enhanced_feature_reg[3:2];             // [R08]
  assign rx_mode    = enhanced_feature_reg[1:0];             // [R09]
  assign halt_lvl   = {1'b0, flow_threshold_reg[3:0], 2'h0}; // [R05]
  assign resume_lvl = {1'b0, flow_threshold_reg[7:4], 2'h0}; // [R06]
  assign mask       = ufc_wl_mask(line_ctrl[1:0]);

  ufc_sync2 #(
    .RST_VAL (1'b1)
  ) u_cts_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (cts_n),
    .dout  (cts_sync)
  );

  // cts only matters at the moment a new character would start
  assign cts_ok = ~enhanced_feature_reg[FEAT_AUTO_CTS] | ~cts_sync; // [R01] [R02] [R22]
  assign can_go = ~tx_busy & ~tx_start;                             // [R26]

  // auto-rts hysteresis between halt and resume levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_n <= 1'b1;
    end else if (!enhanced_feature_reg[FEAT_AUTO_RTS]) begin       // [R01]
      rts_n <= ~modem_ctrl_reg[MODEM_RTS];
    end else if (rx_level >= halt_lvl) begin
      rts_n <= 1'b1;                                               // [R05] [R07]
    end else if (rx_level <= resume_lvl) begin
      rts_n <= 1'b0;                                               // [R06]
    end
  end

  function automatic ufc_seq_t make_seq(input logic [1:0] sel, input logic [7:0] a,
                                        input logic [7:0] b);
    make_seq.c0  = sel[1] ? a : b;                                 // [R08]
    make_seq.c1  = b;
    make_seq.cnt = (sel == 2'h3) ? 2'h2 : 2'h1;
  endfunction

  // software flow transmit sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q         <= '0;
      halt_sent <= 1'b0;
      sent_sel  <= 2'h0;
    end else if (q.cnt != 2'h0) begin
      if (can_go) begin
        q.c0  <= q.c1;
        q.cnt <= q.cnt - 2'h1;
      end
    end else if (halt_sent && (rx_level <= resume_lvl || tx_sel != sent_sel)) begin
      q         <= make_seq(sent_sel, fchar[CH_RES1], fchar[CH_RES2]);    // [R16] [R17]
      halt_sent <= 1'b0;
    end else if (!halt_sent && tx_sel != 2'h0 && rx_level >= halt_lvl) begin
      q         <= make_seq(tx_sel, fchar[CH_HALT1], fchar[CH_HALT2]);    // [R15] [R17]
      halt_sent <= 1'b1;
      sent_sel  <= tx_sel;
    end
  end

  // transmit launch; flow characters win between fifo characters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_start <= 1'b0;
      tx_pop   <= 1'b0;
      tx_char  <= 8'h00;
    end else begin
      tx_start <= 1'b0;
      tx_pop   <= 1'b0;
      if (can_go) begin
        if (q.cnt != 2'h0) begin
          tx_start <= 1'b1;                                         // [R26]
          tx_char  <= q.c0 & mask;                                  // [R18]
        end else if (tx_fifo_valid && cts_ok && !xoff_halt) begin   // [R03] [R04] [R12]
          tx_start <= 1'b1;
          tx_pop   <= 1'b1;
          tx_char  <= tx_fifo_data & mask;
        end
      end
    end
  end

  // receive comparison
  for (genvar i = 0; i < 4; i++) begin : g_match
    ufc_char_match u_match (
      .rx_char   (rx_in.data),
      .flow_char (fchar[i]),
      .wl        (line_ctrl[1:0]),
      .hit       (m[i])
    );
  end

  always_comb begin
    either   = (rx_mode == 2'h3) & (tx_sel == 2'h1 || tx_sel == 2'h2);        // [R09]
    pair     = (rx_mode == 2'h3) & (tx_sel == 2'h0 || tx_sel == 2'h3);
    ok       = rx_valid & ~rx_in.err;                                       // [R14] [R25]
    any_res  = ok & modem_ctrl_reg[MODEM_ANY_RES] & xoff_halt;              // [R10]
    sng_off  = ((rx_mode == 2'h2) & m[CH_HALT1]) | ((rx_mode == 2'h1) & m[CH_HALT2])
             | (either & (m[CH_HALT1] | m[CH_HALT2]));
    sng_on   = ((rx_mode == 2'h2) & m[CH_RES1]) | ((rx_mode == 2'h1) & m[CH_RES2])
             | (either & (m[CH_RES1] | m[CH_RES2]));
    pair_off = pair & pair_pend & ~pair_kind & m[CH_HALT2];
    pair_on  = pair & pair_pend & pair_kind & m[CH_RES2];
    new_pend = ok & pair & ~any_res & ~pair_off & ~pair_on & (m[CH_HALT1] | m[CH_RES1]);
    do_off   = ok & ~any_res & (sng_off | pair_off);                        // [R12]
    do_on    = ok & (any_res | sng_on | pair_on);                           // [R13] [R10]
    // first resume char taken by any-resume leaves a following second one as data
    eat      = ok & (sng_off | sng_on | pair_off | pair_on | new_pend
             | (any_res & (m[CH_RES1] | m[CH_RES2])));                      // [R21]
    flush    = rx_valid & pair_pend & ~pair_off & ~pair_on;                 // [R19]
    flag_set = do_off | (ok & enhanced_feature_reg[FEAT_SPECIAL] & m[CH_HALT2]); // [R11]
    flag_clr = do_on | ident_read;                                          // [R23]
  end

  // receive path into receive_queue; a flushed pair head delays one character
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_store      <= 1'b0;
      rx_store_char <= '0;
      stash_v       <= 1'b0;
      stash_c       <= '0;
      pair_pend     <= 1'b0;
      pair_kind     <= 1'b0;
      pair_char     <= '0;
    end else begin
      rx_store <= 1'b0;
      if (stash_v) begin
        rx_store      <= 1'b1;
        rx_store_char <= stash_c;
        stash_v       <= 1'b0;
      end
      if (rx_valid) begin
        pair_pend <= new_pend;
        pair_kind <= ~m[CH_HALT1] & m[CH_RES1];
        pair_char <= rx_in;
        if (flush) begin
          rx_store      <= 1'b1;
          rx_store_char <= pair_char;                               // [R19]
          stash_v       <= ~eat;
          stash_c       <= rx_in;
        end else if (!eat) begin
          rx_store      <= 1'b1;
          rx_store_char <= rx_in;                                   // [R14] [R11]
        end
      end
    end
  end

  // halt state and xoff flag; a set in the clear cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xoff_halt <= 1'b0;
      xoff_flag <= 1'b0;
      int_out   <= 1'b0;
    end else begin
      if (rx_mode == 2'h0) begin
        xoff_halt <= 1'b0;
      end else if (do_off) begin
        xoff_halt <= 1'b1;                                          // [R12]
      end else if (do_on) begin
        xoff_halt <= 1'b0;                                          // [R13]
      end
      if (flag_set) begin
        xoff_flag <= 1'b1;                                          // [R11] [R12]
      end else if (flag_clr) begin
        xoff_flag <= 1'b0;                                          // [R13] [R23]
      end
      int_out <= xoff_flag & int_enable_reg[INTEN_HALT];            // [R12]
    end
  end
endmodule

// File: bench/ufc_chk.sv
// Purpose: concurrent checks at the ports of the flow control block
// Assumes: feature, threshold and enable bits mirrored from apb writes
// Notes:   mirrors reset with nrst, the same values the registers take
`timescale 1ns/10ps
module ufc_chk
  import ufc_pkg::*;
(
  // clock and reset
  input wire logic                       clk,
  input wire logic                       nrst,
  // apb
  input wire logic [ufc_pkg::ADDR_W-1:0] paddr,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // modem and transmit
  input wire logic                       cts_n,
  input wire logic                       rts_n,
  input wire logic                       tx_pop,
  input wire logic                       tx_busy,
  input wire logic                       tx_start,
  // receive and interrupt
  input wire logic                       rx_valid,
  input wire ufc_pkg::ufc_rx_t           rx_in,
  input wire logic [6:0]                 rx_level,
  input wire logic                       rx_store,
  input wire ufc_pkg::ufc_rx_t           rx_store_char,
  input wire logic                       int_out
);
  logic [7:0] feat;
  logic [7:0] thresh;
  logic       inten_halt;
  logic [6:0] halt_lvl;
  logic [6:0] res_lvl;
  assign halt_lvl = {1'b0, thresh[3:0], 2'b00};
  assign res_lvl  = {1'b0, thresh[7:4], 2'b00};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      feat       <= 8'h00;
      thresh     <= 8'h00;
      inten_halt <= 1'b0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == OFF_FEAT) feat <= pwdata[7:0];
      if (paddr == OFF_THRESH) thresh <= pwdata[7:0];
      if (paddr == OFF_INTEN) inten_halt <= pwdata[INTEN_HALT];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_setup;
    psel && !penable;
  endsequence
  // two sync flops plus the launch register: four samples cover the lag
  sequence s_cts_held;
    (feat[FEAT_AUTO_CTS] && cts_n) [*4];
  endsequence
  AST_PREADY: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  AST_SLVERR: assert property (s_setup |=> (pslverr == ($past(paddr) > OFF_STATUS)))
    else $error("slave error does not match address");
  AST_CTS_HOLD: assert property (s_cts_held |=> !tx_pop)
    else $error("fifo character launched while cts high");
  AST_RTS_HALT: assert property (feat[FEAT_AUTO_RTS] && res_lvl < halt_lvl &&
    rx_level >= halt_lvl |=> rts_n) else $error("rts asserted at halt level");
  AST_RTS_RESUME: assert property (feat[FEAT_AUTO_RTS] && res_lvl < halt_lvl &&
    rx_level <= res_lvl |=> !rts_n) else $error("rts not asserted at resume level");
  AST_INT_EN: assert property (int_out |-> $past(inten_halt))
    else $error("interrupt output while disabled");
  AST_POP_START: assert property (tx_pop |-> tx_start)
    else $error("pop without start");
  AST_START_BUSY: assert property (tx_start |-> !$past(tx_busy) ##1 !tx_start)
    else $error("start while shifter busy");
  AST_ERR_STORE: assert property (rx_valid && rx_in.err |->
    ##[1:2] (rx_store && rx_store_char.err)) else $error("errored character not stored");
endmodule

// File: bench/ufc_remote.sv
// Purpose: remote side model, a transmit shifter feeding a remote receiver
// Assumes: one character lasts CHAR_CYC clock cycles on the line
// Notes:   busy rises the cycle after a start, as the launcher expects
`timescale 1ns/10ps
module ufc_remote #(
  parameter int CHAR_CYC = 20
) (
  // clock
  input  wire logic       clk,
  // transmit side
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_char,
  output logic            tx_busy
);
  logic [7:0] log_q [16];
  int         n_got = 0;
  int         cnt   = 0;
  assign tx_busy = (cnt != 0);
  // a start mid-character is logged as garbage so the bench sees it
  always @(posedge clk) begin
    if (tx_start === 1'b1) begin
      log_q[n_got[3:0]] <= (cnt != 0) ? 8'hee : tx_char;
      n_got <= n_got + 1;
      cnt   <= CHAR_CYC;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// File: bench/ufc_flow_ctrl_tb_top.sv
// Purpose: self-checking bench for the flow control block
// Assumes: zero wait apb slave, remote model logs every launched character
// Notes:   bench stands in for the local receiver and the receive queue
`timescale 1ns/10ps
module ufc_flow_ctrl_tb_top;
  import ufc_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        cts_n = 1'b1;
  logic        rx_valid = 1'b0;
  ufc_rx_t     rx_in = '0;
  logic [6:0]  rx_level = 7'h00;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rts_n;
  logic        tx_pop;
  logic        tx_busy;
  logic        tx_start;
  logic [7:0]  tx_char;
  logic        rx_store;
  ufc_rx_t     rx_store_char;
  logic        int_out;
  logic        tx_fifo_valid;
  logic [7:0]  tx_fifo_data;
  logic [7:0]  fd [8];
  logic [6:0]  lv [4] = '{7'h0f, 7'h10, 7'h0a, 7'h08};
  logic [3:0]  ex = 4'h6;
  logic [31:0] rv;
  logic        ev;
  ufc_rx_t     st_last = '0;
  int          st_n = 0;
  int          sn;
  int          nf = 0;
  int          fi = 0;
  int          failures = 0;
  int          comparisons = 0;
  assign tx_fifo_valid = (fi < nf);
  assign tx_fifo_data  = fd[fi[2:0]];
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (tx_pop === 1'b1) fi <= fi + 1;
    if (rx_store === 1'b1) st_n <= st_n + 1;
    if (rx_store === 1'b1) st_last <= rx_store_char;
  end
  ufc_flow_ctrl dut_u (.clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .cts_n, .rts_n, .tx_fifo_valid, .tx_fifo_data, .tx_pop, .tx_busy,
    .tx_start, .tx_char, .rx_valid, .rx_in, .rx_level, .rx_store, .rx_store_char, .int_out);
  ufc_remote #(.CHAR_CYC(20)) rem_u (.clk, .tx_start, .tx_char, .tx_busy);
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    paddr  <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    psel   <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 8'h00);
    cmp(rv, e);
  endtask
  task automatic rxc(input logic e, input logic [7:0] d);
    rx_valid <= 1'b1;
    rx_in    <= {e, d};
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_in    <= ~{e, d};
    wt(4);
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    wt(20);
    nrst <= 1'b1;
    wt(4);
  endtask
  task automatic report_and_stop();
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // whole sequence needs under 2000 cycles
  initial begin
    wt(12000);
    failures++;
    report_and_stop();
  end
  initial begin
    do_reset();
    apb(OFF_HALT1, 1'b1, 8'hf3);
    apb(OFF_FEAT, 1'b1, 8'h80);
    do_reset();
    rd(OFF_HALT1, 32'hf3);
    rd(OFF_FEAT, 32'h0);
    rd(OFF_INTID, {26'h0, INTID_NONE});
    rd(8'h40, 32'h0);
    cmp(ev, 1'b1);
    apb(OFF_RES1, 1'b1, 8'hd1);
    // every flow slot gets a value: unwritten slots would feed unknowns to the matchers
    apb(OFF_RES2, 1'b1, 8'hd3);
    apb(OFF_HALT2, 1'b1, 8'h93);
    apb(OFF_FEAT, 1'b1, 8'h80);
    fd[0] <= 8'h41;
    fd[1] <= 8'h42;
    nf    <= 2;
    wt(40);
    cmp(rem_u.n_got, 0);
    cts_n <= 1'b0;
    wt(60);
    cmp(rem_u.n_got, 2);
    fd[2] <= 8'h43;
    fd[3] <= 8'h44;
    nf    <= 4;
    wt(6);
    cts_n <= 1'b1;
    wt(60);
    cmp(rem_u.n_got, 3);
    apb(OFF_FEAT, 1'b1, 8'h00);
    wt(10);
    cmp(rem_u.log_q[3], 8'h44);
    apb(OFF_THRESH, 1'b1, 8'h24);
    apb(OFF_FEAT, 1'b1, 8'h40);
    for (int k = 0; k < 4; k++) begin
      rx_level <= lv[k];
      wt(4);
      cmp(rts_n, ex[k]);
    end
    rx_level <= 7'h10;
    wt(4);
    rxc(1'b0, 8'h61);
    cmp(st_last, 9'h061);
    rx_level <= 7'h00;
    apb(OFF_FEAT, 1'b1, 8'h00);
    apb(OFF_INTEN, 1'b1, 8'h20);
    apb(OFF_FEAT, 1'b1, 8'h0a);
    rxc(1'b0, 8'hf3);
    cmp(int_out, 1'b1);
    cmp(st_last, 9'h061);
    fd[4] <= 8'h45;
    nf    <= 5;
    wt(40);
    cmp(rem_u.n_got, 4);
    rd(OFF_INTID, {26'h0, INTID_HALT});
    rd(OFF_INTID, {26'h0, INTID_NONE});
    rxc(1'b0, 8'hd1);
    wt(30);
    cmp(rem_u.log_q[4], 8'h45);
    apb(OFF_LCR, 1'b1, 8'h00);
    rx_level <= 7'h10;
    wt(30);
    cmp(rem_u.log_q[5], 8'h13);
    rx_level <= 7'h08;
    wt(30);
    cmp(rem_u.log_q[6], 8'h11);
    apb(OFF_LCR, 1'b1, 8'h03);
    rx_level <= 7'h00;
    rxc(1'b1, 8'hf3);
    cmp(st_last, 9'h1f3);
    fd[5] <= 8'h46;
    nf    <= 6;
    wt(30);
    cmp(rem_u.n_got, 8);
    apb(OFF_MODEM, 1'b1, 8'h20);
    rxc(1'b0, 8'hf3);
    rxc(1'b0, 8'h55);
    cmp(st_last, 9'h055);
    fd[6] <= 8'h47;
    nf    <= 7;
    wt(30);
    cmp(rem_u.n_got, 9);
    apb(OFF_MODEM, 1'b1, 8'h00);
    apb(OFF_FEAT, 1'b1, 8'h03);
    sn = st_n;
    rxc(1'b0, 8'hf3);
    rxc(1'b0, 8'h55);
    cmp(st_n, sn + 2);
    apb(OFF_INTID, 1'b0, 8'h00);
    apb(OFF_HALT2, 1'b1, 8'h93);
    apb(OFF_FEAT, 1'b1, 8'h20);
    rxc(1'b0, 8'h93);
    cmp(st_last, 9'h093);
    rd(OFF_INTID, {26'h0, INTID_HALT});
    report_and_stop();
  end
endmodule
bind ufc_flow_ctrl ufc_chk chk_u (.clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata,
  .prdata, .pready, .pslverr, .cts_n, .rts_n, .tx_pop, .tx_busy, .tx_start, .rx_valid,
  .rx_in, .rx_level, .rx_store, .rx_store_char, .int_out);
